// >>> design/psmc_consts.svh
// constants for the stop/sleep power control block
`ifndef PSMC_CONSTS_SVH
`define PSMC_CONSTS_SVH

`define PSMC_CTRL_W 8
`define PSMC_CTRL_RST 8'h00
`define PSMC_CTRL_SLEEP 8'h0f
`define PSMC_CTRL_STOP 8'h5a
`define PSMC_DIV_W 3
`define PSMC_BIT_DIV_RST 3'h7
`define PSMC_BIT_ZERO 8'h00
`define PSMC_BIT_MAX 8'hff
`define PSMC_PRE_W 8
`define PSMC_PRE_ONE 8'h01
`define PSMC_PRE_ZERO 8'h00

`endif

// >>> design/psmc_pkg.sv
// types shared by the stop/sleep power control block
package psmc_pkg;

  typedef enum logic [2:0] {
    PSMC_RST_STAB,
    PSMC_RUN,
    PSMC_SLEEP,
    PSMC_STOP,
    PSMC_WAKE_STAB
  } psmc_state_t;

  typedef struct packed {
    logic main_osc;
    logic sub_osc;
  } psmc_osc_t;

  typedef struct packed {
    logic adc;
    logic usart;
    logic sio;
    logic iic;
    logic bit_timer;
    logic wdt;
    logic wt_sys;
    logic tc_sys;
    logic buz_sys;
    logic wt_sub;
    logic tc_sub;
    logic buz_sub;
  } psmc_periph_t;

endpackage : psmc_pkg

// >>> design/psmc_ctrl_reg.sv
// stop_sleep_control byte register with hardware clear
`timescale 1ns/1ps
`include "psmc_consts.svh"

module psmc_ctrl_reg (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic [`PSMC_CTRL_W-1:0] i_wdata,
  input wire logic i_clear,
  output logic [`PSMC_CTRL_W-1:0] o_value
);
  import psmc_pkg::*;

  // core is halted while a clear can occur, so no write competes with it
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_value <= `PSMC_CTRL_RST;
    end else if (i_clear) begin
      o_value <= `PSMC_CTRL_RST;
    end else if (i_wr) begin
      o_value <= i_wdata;
    end
  end

  a_ctrl_hw_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_clear |=> (o_value == `PSMC_CTRL_RST))
    else $error("control byte not cleared on stop release");

endmodule : psmc_ctrl_reg

// >>> design/psmc_stab_timer.sv
// basic interval timer used as the oscillator stabilizing counter
`timescale 1ns/1ps
`include "psmc_consts.svh"

module psmc_stab_timer (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_run,
  input wire logic [`PSMC_DIV_W-1:0] i_div,
  output logic [7:0] o_count,
  output logic o_done
);
  import psmc_pkg::*;

  logic [`PSMC_PRE_W-1:0] pre;
  logic [`PSMC_PRE_W-1:0] pre_last;
  logic tick;

  // division code n gives one timer step every 2**n clocks
  assign pre_last = (`PSMC_PRE_ONE << i_div) - `PSMC_PRE_ONE;
  assign tick = i_run && (pre == pre_last);
  assign o_done = tick && (o_count == `PSMC_BIT_MAX);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || i_start || !i_run) begin
      pre <= `PSMC_PRE_ZERO;
    end else if (tick) begin
      pre <= `PSMC_PRE_ZERO;
    end else begin
      pre <= pre + `PSMC_PRE_ONE;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || i_start) begin
      o_count <= `PSMC_BIT_ZERO;
    end else if (tick) begin
      o_count <= o_count + 8'h01;
    end
  end

  a_count_from_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_start |=> (o_count == `PSMC_BIT_ZERO) && !o_done)
    else $error("stabilizing count did not restart at zero");

  a_done_at_max: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_done |-> (o_count == `PSMC_BIT_MAX) && i_run && (pre == pre_last))
    else $error("stabilizing end not at full timer cycle");

endmodule : psmc_stab_timer

// >>> design/power_saving_mode_control.sv
// stop/sleep power control: oscillator, peripheral and core gating with wake-up stabilizing
// Function
// - entering stop halts the oscillator selected as system clock source.
// - during stop the unselected oscillator keeps running if it already ran.
// - stop on main oscillator with sub active lets the watch timer count on sub.
// - sub-clocked watch timer runs in stop-main and sleep, halts in stop-sub.
// - sub-clocked buzzer and timer/counter run in stop-main and sleep, halt in stop-sub.
// - system-clocked watch timer halts in either stop, runs in sleep.
// - after reset and after waking, a stabilizing interval precedes execution.
// - stabilizing interval is exactly one full basic interval timer cycle.
// - software-programmed timer division sets the wake-up stabilizing length.
// - after reset the stabilizing interval uses the default division.
// - on wake the timer counts up from zero, overflow releases the core.
// - stop release clears the stop/sleep control byte automatically.
// - wake with interrupt mask clear resumes after power-down instruction, no vector.
`timescale 1ns/1ps
`include "psmc_consts.svh"

module power_saving_mode_control (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_ctrl_wr,
  input wire logic [`PSMC_CTRL_W-1:0] i_ctrl_wdata,
  input wire logic i_stop_instr,
  input wire logic i_sys_sel_sub,
  input wire psmc_pkg::psmc_osc_t i_osc_en,
  input wire logic [`PSMC_DIV_W-1:0] i_bit_div,
  input wire logic i_wake_irq,
  input wire logic i_iflag,
  input wire logic i_sio_ext_clk,
  output logic [`PSMC_CTRL_W-1:0] o_stop_sleep_control,
  output psmc_pkg::psmc_state_t o_mode,
  output logic o_cpu_run,
  output logic o_retain,
  output psmc_pkg::psmc_osc_t o_osc_run,
  output psmc_pkg::psmc_periph_t o_periph_run,
  output logic o_wake_vector,
  output logic o_wake_resume
);
  import psmc_pkg::*;

  psmc_state_t state;
  psmc_state_t next_state;
  logic stop_on_sub;
  logic vector_pend;
  logic stab_start;
  logic stab_run;
  logic stab_done;
  logic [`PSMC_DIV_W-1:0] stab_div;
  logic stop_release;
  logic sleep_req;
  logic stop_req;
  logic [7:0] stab_count;
  psmc_osc_t next_osc;
  psmc_periph_t next_periph;

  // entry decode; a stop instruction without the key byte is a no-op
  assign sleep_req = i_ctrl_wr && (i_ctrl_wdata == `PSMC_CTRL_SLEEP);
  assign stop_req = i_stop_instr && (o_stop_sleep_control == `PSMC_CTRL_STOP);
  assign stop_release = (state == PSMC_STOP) && i_wake_irq;

  psmc_ctrl_reg u_ctrl (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_wr(i_ctrl_wr && (state == PSMC_RUN)),
    .i_wdata(i_ctrl_wdata),
    .i_clear(stop_release),
    .o_value(o_stop_sleep_control)
  );

  // reset wipes the division register, so the default applies there
  assign stab_div = (state == PSMC_RST_STAB) ? `PSMC_BIT_DIV_RST : i_bit_div;
  assign stab_run = (state == PSMC_RST_STAB) || (state == PSMC_WAKE_STAB);
  assign stab_start = (next_state == PSMC_WAKE_STAB) && (state != PSMC_WAKE_STAB);

  psmc_stab_timer u_stab (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_start(stab_start),
    .i_run(stab_run),
    .i_div(stab_div),
    .o_count(stab_count),
    .o_done(stab_done)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      PSMC_RST_STAB: begin
        if (stab_done) begin
          next_state = PSMC_RUN;
        end
      end
      PSMC_RUN: begin
        if (stop_req) begin
          next_state = PSMC_STOP;
        end else if (sleep_req) begin
          next_state = PSMC_SLEEP;
        end
      end
      PSMC_SLEEP: begin
        if (i_wake_irq) begin
          next_state = PSMC_WAKE_STAB;
        end
      end
      PSMC_STOP: begin
        if (i_wake_irq) begin
          next_state = PSMC_WAKE_STAB;
        end
      end
      PSMC_WAKE_STAB: begin
        if (stab_done) begin
          next_state = PSMC_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state <= PSMC_RST_STAB;
    end else begin
      state <= next_state;
    end
  end

  // which oscillator was the system clock when stop was taken
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      stop_on_sub <= 1'b0;
    end else if ((state == PSMC_RUN) && stop_req) begin
      stop_on_sub <= i_sys_sel_sub;
    end
  end

  // interrupt mask at wake decides vectoring once the core is released
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      vector_pend <= 1'b0;
    end else if (stab_start) begin
      vector_pend <= i_iflag;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_wake_vector <= 1'b0;
      o_wake_resume <= 1'b0;
    end else begin
      o_wake_vector <= (state == PSMC_WAKE_STAB) && stab_done && vector_pend;
      o_wake_resume <= (state == PSMC_WAKE_STAB) && stab_done && !vector_pend;
    end
  end

  // outputs follow the next state so they line up with o_mode
  always_comb begin
    next_osc.main_osc = i_osc_en.main_osc;
    next_osc.sub_osc = i_osc_en.sub_osc;
    if (next_state == PSMC_STOP) begin
      if (state == PSMC_STOP ? stop_on_sub : i_sys_sel_sub) begin
        next_osc.sub_osc = 1'b0;
      end else begin
        next_osc.main_osc = 1'b0;
      end
    end
  end

  always_comb begin
    next_periph = '1;
    if (next_state == PSMC_STOP) begin
      next_periph = '0;
      next_periph.sio = i_sio_ext_clk;
      next_periph.iic = 1'b1;
      // sub-clocked units survive only while the sub oscillator does
      if (!(state == PSMC_STOP ? stop_on_sub : i_sys_sel_sub)) begin
        next_periph.wt_sub = i_osc_en.sub_osc;
        next_periph.tc_sub = i_osc_en.sub_osc;
        next_periph.buz_sub = i_osc_en.sub_osc;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_osc_run <= '0;
      o_periph_run <= '0;
      o_cpu_run <= 1'b0;
      o_retain <= 1'b0;
      o_mode <= PSMC_RST_STAB;
    end else begin
      o_osc_run <= next_osc;
      o_periph_run <= next_periph;
      o_cpu_run <= (next_state == PSMC_RUN);
      o_retain <= (next_state == PSMC_SLEEP) || (next_state == PSMC_STOP);
      o_mode <= next_state;
    end
  end

  a_stop_osc_sel: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (o_mode == PSMC_STOP) |-> (stop_on_sub ? !o_osc_run.sub_osc : !o_osc_run.main_osc))
    else $error("selected oscillator still running in stop");

  a_stop_keep_other: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (o_mode == PSMC_STOP) && $past(o_mode == PSMC_STOP) && !stop_on_sub
      |-> (o_osc_run.sub_osc == $past(i_osc_en.sub_osc)))
    else $error("unselected oscillator halted in stop");

  a_wt_sub_stop: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (o_mode == PSMC_STOP) && $past(o_mode == PSMC_STOP)
      |-> (o_periph_run.wt_sub == (!stop_on_sub && o_osc_run.sub_osc)))
    else $error("sub-clocked watch timer wrong in stop");

  a_sub_units_stop: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (o_mode == PSMC_STOP) |-> (o_periph_run.tc_sub == o_periph_run.buz_sub)
      && (stop_on_sub ? !o_periph_run.tc_sub : 1'b1))
    else $error("sub-clocked timer or buzzer wrong in stop");

  // gating outputs still hold their reset zeros on the first edge after release
  a_wt_sys_mode: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_rst_n) |-> (o_periph_run.wt_sys == (o_mode != PSMC_STOP)))
    else $error("system-clocked watch timer wrong in power-down");

  a_sleep_all_run: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (o_mode == PSMC_SLEEP) |-> (o_periph_run == '1) && !o_cpu_run && o_retain)
    else $error("sleep gating wrong");

  a_wake_to_stab: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ((state == PSMC_SLEEP) || (state == PSMC_STOP)) && i_wake_irq
      |=> (state == PSMC_WAKE_STAB) && !o_cpu_run && (stab_count == `PSMC_BIT_ZERO))
    else $error("wake did not enter stabilizing");

  a_reset_div: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state == PSMC_RST_STAB) |-> (stab_div == `PSMC_BIT_DIV_RST) && !o_cpu_run)
    else $error("reset stabilizing not on default division");

  a_stab_release: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    stab_run && stab_done |=> (state == PSMC_RUN) && o_cpu_run)
    else $error("timer overflow did not release the core");

  a_stop_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    stop_release |=> (o_stop_sleep_control == `PSMC_CTRL_RST))
    else $error("control byte kept after stop release");

  a_resume_novec: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state == PSMC_WAKE_STAB) && stab_done && !vector_pend |=> o_wake_resume && !o_wake_vector)
    else $error("masked wake vectored");

  a_mask_capture: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    stab_start |=> (vector_pend == $past(i_iflag)))
    else $error("interrupt mask not captured at wake");

  a_stop_entry: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state == PSMC_RUN) && i_stop_instr && (o_stop_sleep_control != `PSMC_CTRL_STOP)
      |=> (state != PSMC_STOP))
    else $error("stop taken without key byte");

  a_stop_taken: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state == PSMC_RUN) && stop_req |=> (state == PSMC_STOP) && (o_mode == PSMC_STOP))
    else $error("keyed stop not taken");

  a_sleep_entry: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state == PSMC_RUN) && sleep_req && !stop_req
      |=> (state == PSMC_SLEEP) && (o_stop_sleep_control == `PSMC_CTRL_SLEEP))
    else $error("sleep byte did not enter sleep");

  a_stop_cpu_halt: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (o_mode == PSMC_STOP) |-> !o_cpu_run && o_retain)
    else $error("core running or state lost in stop");

  a_cpu_run_mode: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_cpu_run == (o_mode == PSMC_RUN))
    else $error("core enable out of step with mode");

  a_retain_mode: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_retain == ((o_mode == PSMC_SLEEP) || (o_mode == PSMC_STOP)))
    else $error("retention out of step with mode");

  a_stop_sys_units: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (o_mode == PSMC_STOP) |-> !o_periph_run.adc && !o_periph_run.usart && !o_periph_run.wdt
      && !o_periph_run.bit_timer && !o_periph_run.tc_sys && !o_periph_run.buz_sys)
    else $error("system-clocked unit running in stop");

  a_stop_sio_iic: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (o_mode == PSMC_STOP) |-> o_periph_run.iic && (o_periph_run.sio == $past(i_sio_ext_clk)))
    else $error("serial or iic slave gating wrong in stop");

  a_stop_sub_halt: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (o_mode == PSMC_STOP) && stop_on_sub |-> !o_osc_run.sub_osc && !o_periph_run.wt_sub)
    else $error("sub oscillator or watch timer running in stop on sub");

  a_wake_cpu_held: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    stab_run |-> !o_cpu_run)
    else $error("core released during stabilizing");

  a_wake_div_used: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state == PSMC_WAKE_STAB) |-> (stab_div == i_bit_div))
    else $error("wake stabilizing ignores programmed division");

  a_pulse_single: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (o_wake_resume || o_wake_vector) |=> !o_wake_resume && !o_wake_vector)
    else $error("wake pulse longer than one cycle");

endmodule : power_saving_mode_control

// >>> verif/power_saving_mode_control_tb.sv
// self-checking bench for the stop/sleep power control block
`timescale 1ns/1ps
`include "psmc_consts.svh"

module power_saving_mode_control_tb;
  import psmc_pkg::*;
  logic i_clock;
  logic i_rst_n;
  logic i_ctrl_wr;
  logic [7:0] i_ctrl_wdata;
  logic i_stop_instr;
  logic i_sys_sel_sub;
  psmc_osc_t i_osc_en;
  logic [2:0] i_bit_div;
  logic i_wake_irq;
  logic i_iflag;
  logic i_sio_ext_clk;
  logic [7:0] o_stop_sleep_control;
  psmc_state_t o_mode;
  logic o_cpu_run;
  logic o_retain;
  psmc_osc_t o_osc_run;
  psmc_periph_t o_periph_run;
  logic o_wake_vector;
  logic o_wake_resume;
  integer seed;
  integer n_fail;
  integer tests_run;
  logic sel;
  logic fl;
  logic [2:0] dv;

  power_saving_mode_control dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_ctrl_wr(i_ctrl_wr),
    .i_ctrl_wdata(i_ctrl_wdata), .i_stop_instr(i_stop_instr), .i_sys_sel_sub(i_sys_sel_sub),
    .i_osc_en(i_osc_en), .i_bit_div(i_bit_div), .i_wake_irq(i_wake_irq), .i_iflag(i_iflag),
    .i_sio_ext_clk(i_sio_ext_clk), .o_stop_sleep_control(o_stop_sleep_control), .o_mode(o_mode),
    .o_cpu_run(o_cpu_run), .o_retain(o_retain), .o_osc_run(o_osc_run), .o_periph_run(o_periph_run),
    .o_wake_vector(o_wake_vector), .o_wake_resume(o_wake_resume));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // in stop the iic slave, the sio on external clock and the sub-clocked units survive, the latter only when main drives the core
  function automatic psmc_periph_t exp_stop(input logic sub_sel, input psmc_osc_t en, input logic ext);
    psmc_periph_t p;
    p = 12'h000;
    p.sio = ext;
    p.iic = 1'b1;
    p.wt_sub = en.sub_osc & ~sub_sel;
    p.tc_sub = en.sub_osc & ~sub_sel;
    p.buz_sub = en.sub_osc & ~sub_sel;
    return p;
  endfunction : exp_stop

  function automatic psmc_osc_t exp_osc(input logic sub_sel, input psmc_osc_t en);
    psmc_osc_t o;
    o.main_osc = en.main_osc & sub_sel;
    o.sub_osc = en.sub_osc & ~sub_sel;
    return o;
  endfunction : exp_osc

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic wr_ctrl(input logic [7:0] d);
    @(posedge i_clock);
    i_ctrl_wr <= 1'b1;
    i_ctrl_wdata <= d;
    @(posedge i_clock);
    i_ctrl_wr <= 1'b0;
    #1;
  endtask : wr_ctrl

  task automatic pulse_stop;
    @(posedge i_clock);
    i_stop_instr <= 1'b1;
    @(posedge i_clock);
    i_stop_instr <= 1'b0;
    #1;
  endtask : pulse_stop

  task automatic wake(input logic f);
    @(posedge i_clock);
    i_wake_irq <= 1'b1;
    i_iflag <= f;
    @(posedge i_clock);
    i_wake_irq <= 1'b0;
    #1;
    check("mode after wake", PSMC_WAKE_STAB, o_mode);
    check("cpu held", 1'b0, o_cpu_run);
  endtask : wake

  // counts edges until run; pulses are only defined at the end of a wake
  task automatic wait_run(input integer exp, input integer slack, input logic chk, input logic [1:0] pulses);
    integer n;
    n = 0;
    while (o_mode !== PSMC_RUN && n < exp + slack + 8) begin
      @(posedge i_clock);
      #1;
      n = n + 1;
    end
    if (o_mode !== PSMC_RUN) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED run wait expected %0d seen timeout", exp);
      test_done();
    end
    tests_run = tests_run + 1;
    if (n < exp || n > exp + slack) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED stabilizing cycles expected %0d seen %0d", exp, n);
    end
    check("cpu run", 1'b1, o_cpu_run);
    if (chk) begin
      check("wake pulses", pulses, {o_wake_vector, o_wake_resume});
    end
  endtask : wait_run

  initial begin
    seed = 32'hdfd4;
    n_fail = 0;
    tests_run = 0;
    i_rst_n = 1'b0;
    i_ctrl_wr = 1'b0;
    i_ctrl_wdata = 8'h00;
    i_stop_instr = 1'b0;
    i_sys_sel_sub = 1'b0;
    i_osc_en = 2'h3;
    i_bit_div = 3'h0;
    i_wake_irq = 1'b0;
    i_iflag = 1'b0;
    i_sio_ext_clk = 1'b0;
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    #1;
    check("mode in reset", PSMC_RST_STAB, o_mode);
    check("byte in reset", `PSMC_CTRL_RST, o_stop_sleep_control);
    // input division is 0 here, yet reset must count with the default
    wait_run(256 << `PSMC_BIT_DIV_RST, 1, 1'b0, 2'h0);
    $display("test reset done");
    @(posedge i_clock);
    i_bit_div <= 3'h1;
    i_osc_en <= 2'($random(seed));
    wr_ctrl(`PSMC_CTRL_SLEEP);
    check("sleep byte", `PSMC_CTRL_SLEEP, o_stop_sleep_control);
    check("sleep mode", PSMC_SLEEP, o_mode);
    check("sleep cpu/retain", 2'b01, {o_cpu_run, o_retain});
    check("sleep osc", i_osc_en, o_osc_run);
    check("sleep periph", 12'hfff, o_periph_run);
    wr_ctrl(`PSMC_CTRL_STOP);
    check("write refused", `PSMC_CTRL_SLEEP, o_stop_sleep_control);
    wake(1'b1);
    check("sleep byte kept", `PSMC_CTRL_SLEEP, o_stop_sleep_control);
    wait_run(512, 0, 1'b1, 2'b10);
    $display("test sleep done");
    wr_ctrl(8'h33);
    pulse_stop();
    check("stop refused", PSMC_RUN, o_mode);
    check("odd byte", 8'h33, o_stop_sleep_control);
    $display("test refused stop done");
    for (int k = 0; k < 8; k++) begin
      sel = k[0];
      dv = 3'(k % 3);
      fl = 1'($random(seed));
      @(posedge i_clock);
      i_sys_sel_sub <= sel;
      i_osc_en <= (k < 2) ? 2'h3 : 2'($random(seed));
      i_sio_ext_clk <= 1'($random(seed));
      i_bit_div <= dv;
      wr_ctrl(`PSMC_CTRL_STOP);
      check("stop byte", `PSMC_CTRL_STOP, o_stop_sleep_control);
      pulse_stop();
      check("stop mode", PSMC_STOP, o_mode);
      check("stop cpu/retain", 2'b01, {o_cpu_run, o_retain});
      check("stop osc", exp_osc(sel, i_osc_en), o_osc_run);
      check("stop periph", exp_stop(sel, i_osc_en, i_sio_ext_clk), o_periph_run);
      wake(fl);
      check("byte cleared", 8'h00, o_stop_sleep_control);
      wait_run(256 << dv, 0, 1'b1, {fl, ~fl});
    end
    $display("test stop done");
    test_done();
  end
endmodule : power_saving_mode_control_tb
